// ===== hw/lbu_defs.vh
// Constants for the logic and bit-field unit: register map, instruction fields, codes
`ifndef LBU_DEFS_VH
`define LBU_DEFS_VH

// Register byte offsets (low eight address bits)
`define LBU_OFS_SRC_A    8'h00
`define LBU_OFS_SRC_B    8'h04
`define LBU_OFS_DEST     8'h08
`define LBU_OFS_STATUS   8'h0C
`define LBU_OFS_MASK     8'h10
`define LBU_OFS_INSTR    8'h14
`define LBU_OFS_COND     8'h18

// Status word layout: shift amount and field length
`define LBU_SAR_HI       4
`define LBU_SAR_LO       0
`define LBU_FLR_HI       12
`define LBU_FLR_LO       8

// Reset values
`define LBU_RST_WORD     32'h0000_0000
`define LBU_RST_FIVE     5'h00

// Instruction word fields
`define LBU_OP_HI        23
`define LBU_OP_LO        21
`define LBU_LEN_HI       15
`define LBU_LEN_LO       11
`define LBU_SHF_HI       10
`define LBU_SHF_LO       6
`define LBU_MBIT         5
`define LBU_SCON_HI      4
`define LBU_SCON_LO      0
`define LBU_LSEL         10
`define LBU_LEXT_HI      9
`define LBU_LEXT_LO      6
`define LBU_BTEST        5
`define LBU_DSUB_HI      10
`define LBU_DSUB_LO      8
`define LBU_DEXT_HI      7
`define LBU_DEXT_LO      5
`define LBU_MSUB4_HI     10
`define LBU_MSUB4_LO     7
`define LBU_MSUB2_HI     6
`define LBU_MSUB2_LO     5
`define LBU_WCON_HI      15
`define LBU_WCON_LO      0

// Primary opcodes
`define LBU_OPC_DEP      3'h0
`define LBU_OPC_MIMM     3'h1
`define LBU_OPC_MHWH     3'h3
`define LBU_OPC_DYN      3'h4
`define LBU_OPC_LOGIC    3'h5
`define LBU_OPC_EXT      3'h6
`define LBU_OPC_MISC     3'h7

// Sub-field codes
`define LBU_DYN_MARK     3'h7
`define LBU_MISC_MARK    4'hF
`define LBU_MISC_BMERGE  2'h1
`define LBU_MISC_EXCH    2'h2

// Logical function codes
`define LBU_LF_ZERO      4'hF
`define LBU_LF_AND       4'hE
`define LBU_LF_ANDN      4'hD
`define LBU_LF_PASSA     4'hC
`define LBU_LF_NAND2     4'hB
`define LBU_LF_PASSB     4'hA
`define LBU_LF_XOR       4'h9
`define LBU_LF_OR        4'h8
`define LBU_LF_NOR       4'h7
`define LBU_LF_XNOR      4'h6
`define LBU_LF_NOTB      4'h5
`define LBU_LF_ORN       4'h4
`define LBU_LF_NOTA      4'h3
`define LBU_LF_NOR2      4'h2
`define LBU_LF_NAND      4'h1
`define LBU_LF_ONES      4'h0

// Exchange stage masks
`define LBU_X_NIB        32'h0F0F_0F0F
`define LBU_X_PAIR       32'h3333_3333
`define LBU_X_BIT        32'h5555_5555

// Full field width
`define LBU_FULL_LEN     6'h20

`endif

// ===== hw/lbu_top.v
// Logic and bit-field unit: logical ops, extract/deposit/merge, bitwise merge, exchange
//
// Contract
// - Four-bit code selects sixteen logical functions
// - Logical condition: nonzero, or all bytes nonzero
// - Static takes instruction fields, dynamic takes shift from status, and length from status only when bit 5 is set
// - Extract shifts right arithmetically, keeps low field
// - Field past bit 31 extracts sign-extended
// - Field size zero means thirty-two bits
// - Deposit shifts field left, truncating at 31
// - Merge bit keeps outside bits, else zero
// - Field ops write destination, condition nonzero
// - Merge-immediate inserts sign-extended five-bit constant
// - Dynamic code picks deposit, merge or extract
// - Dynamic shift always from shift-amount field
// - Halfword-high merge fills bits 31 to 16
// - Bitwise merge picks second source where mask
// - Pattern bit i swaps adjacent 2^i fields
// - Patterns give bit, pair, byte reversal
// - Exchange stages run halfword first, bit last
// - Condition appears at end of execute cycle
`timescale 1ns/100ps
`include "lbu_defs.vh"

module lbu_top (
   // Clock and reset
   input  wire        ref_clk,
   input  wire        reset,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Condition output to the sequencer
   output reg         cond_out
);

   // Bus bookkeeping
   reg  [7:0]  wr_addr_r;           // Byte offset of pending write
   reg         wr_pend_r;           // Write data phase in progress
   wire        addr_ok;             // Valid transfer in address phase
   wire        rd_take;             // Read accepted this cycle

   // Architectural registers
   reg  [31:0] src_a_r;             // First source
   reg  [31:0] src_b_r;             // Second source
   reg  [31:0] dest_r;              // Destination, also merge background
   reg  [4:0]  sar_r;               // Shift-amount field
   reg  [4:0]  flr_r;               // Field-length field
   reg  [31:0] mask_r;              // Bitwise merge mask
   reg  [23:0] instr_r;             // Last instruction issued
   reg         known_r;             // Last instruction was recognised

   // Next values, also used for read forwarding
   reg  [31:0] src_a_nxt;
   reg  [31:0] src_b_nxt;
   reg  [31:0] dest_nxt;
   reg  [4:0]  sar_nxt;
   reg  [4:0]  flr_nxt;
   reg  [31:0] mask_nxt;
   reg  [23:0] instr_nxt;
   reg         known_nxt;
   reg         cond_nxt;
   reg  [31:0] rd_mux;              // Read data selected

   // Decode outputs
   wire        exec;                // Instruction write lands this cycle
   wire [23:0] ins;                 // Instruction word on the bus
   wire [2:0]  opc;                 // Primary opcode
   reg         valid;               // Recognised operation
   reg         is_field;            // Result comes from the field unit
   reg         is_ext;              // Field unit extracts
   reg         fmrg;                // Keep bits outside the field
   reg  [4:0]  fsz;                 // Field size, zero means full
   reg  [4:0]  fsh;                 // Shift count
   reg  [31:0] fsrc;                // Field source value
   reg  [31:0] oth_res;             // Result of non-field operations
   reg         btest;               // All-bytes condition requested
   reg  [31:0] lres;                // Logical function result

   // Field unit
   reg  [5:0]  len_eff;             // Effective length, 1 to 32
   reg  [31:0] low_mask;            // Low len_eff bits set
   reg  [31:0] fld_mask;            // Placed field mask
   reg  [31:0] dep_v;               // Deposit or merge result
   reg signed [31:0] sh_v;          // Arithmetic right shift of source
   reg  [31:0] fres;                // Field unit result
   reg  [31:0] res;                 // Final result

   // Exchange stages
   reg  [31:0] x4, x3, x2, x1, x0;

   // Only NONSEQ and SEQ start a transfer; IDLE and BUSY are ignored
   assign addr_ok = hsel & hready & htrans[1];
   assign rd_take = addr_ok & ~hwrite;
   // Issue happens in the data phase of a write to the instruction register
   assign exec    = wr_pend_r & (wr_addr_r == `LBU_OFS_INSTR);
   // Decode straight off the write data, so no extra pipeline cycle is spent
   assign ins     = hwdata[23:0];
   assign opc     = ins[`LBU_OP_HI:`LBU_OP_LO];

   // Logical function table, indexed by the 4-bit code
   always @* begin
      case (ins[`LBU_LEXT_HI:`LBU_LEXT_LO])
         `LBU_LF_ZERO:  lres = 32'h0000_0000;
         `LBU_LF_AND:   lres = src_a_r & src_b_r;
         `LBU_LF_ANDN:  lres = src_a_r & ~src_b_r;
         `LBU_LF_PASSA: lres = src_a_r;
         `LBU_LF_NAND2: lres = ~src_a_r & src_b_r;
         `LBU_LF_PASSB: lres = src_b_r;
         `LBU_LF_XOR:   lres = src_a_r ^ src_b_r;
         `LBU_LF_OR:    lres = src_a_r | src_b_r;
         `LBU_LF_NOR:   lres = ~src_a_r & ~src_b_r;
         `LBU_LF_XNOR:  lres = ~(src_a_r ^ src_b_r);
         `LBU_LF_NOTB:  lres = ~src_b_r;
         `LBU_LF_ORN:   lres = src_a_r | ~src_b_r;
         `LBU_LF_NOTA:  lres = ~src_a_r;
         `LBU_LF_NOR2:  lres = ~src_a_r | src_b_r;
         `LBU_LF_NAND:  lres = ~src_a_r | ~src_b_r;
         default:       lres = 32'hFFFF_FFFF;
      endcase
   end

   // Perfect exchange, halfword stage first, single bit stage last
   always @* begin
      x4 = ins[4] ? {src_b_r[15:0], src_b_r[31:16]} : src_b_r;
      x3 = ins[3] ? {x4[23:16], x4[31:24], x4[7:0], x4[15:8]} : x4;
      x2 = ins[2] ? (((x3 & `LBU_X_NIB) << 4) | ((x3 >> 4) & `LBU_X_NIB)) : x3;
      x1 = ins[1] ? (((x2 & `LBU_X_PAIR) << 2) | ((x2 >> 2) & `LBU_X_PAIR)) : x2;
      // Composition yields 11111 bit reverse, 11110 pair reverse, 11000 byte swap
      x0 = ins[0] ? (((x1 & `LBU_X_BIT) << 1) | ((x1 >> 1) & `LBU_X_BIT)) : x1;
   end

   // Instruction decode
   always @* begin
      valid    = 1'b0;
      is_field = 1'b0;
      is_ext   = 1'b0;
      fmrg     = 1'b0;
      btest    = 1'b0;
      fsz      = ins[`LBU_LEN_HI:`LBU_LEN_LO];
      fsh      = ins[`LBU_SHF_HI:`LBU_SHF_LO];
      fsrc     = src_b_r;
      oth_res  = dest_r;
      case (opc)
         `LBU_OPC_LOGIC: begin
            // Only the register-register form belongs to this unit
            if (!ins[`LBU_LSEL]) begin
               valid   = 1'b1;
               oth_res = lres;
               btest   = ins[`LBU_BTEST];
            end
         end
         `LBU_OPC_DEP: begin
            // Static deposit, size and shift from the instruction
            valid    = 1'b1;
            is_field = 1'b1;
            fmrg     = ins[`LBU_MBIT];
         end
         `LBU_OPC_EXT: begin
            // Static extract, size and shift from the instruction
            valid    = 1'b1;
            is_field = 1'b1;
            is_ext   = 1'b1;
         end
         `LBU_OPC_MIMM: begin
            // Sign-extended small constant merged into the destination
            valid    = 1'b1;
            is_field = 1'b1;
            fmrg     = 1'b1;
            fsrc     = {{27{ins[`LBU_SCON_HI]}}, ins[`LBU_SCON_HI:`LBU_SCON_LO]};
         end
         `LBU_OPC_MHWH: begin
            // Wide constant lands in the upper half, lower half is kept
            valid   = 1'b1;
            oth_res = {ins[`LBU_WCON_HI:`LBU_WCON_LO], dest_r[15:0]};
         end
         `LBU_OPC_DYN: begin
            // Other sub-codes are arithmetic, handled elsewhere
            if (ins[`LBU_DSUB_HI:`LBU_DSUB_LO] == `LBU_DYN_MARK) begin
               fsh = sar_r;
               if (ins[`LBU_DEXT_LO])
                  fsz = flr_r;
               case (ins[`LBU_DEXT_HI:`LBU_DEXT_LO])
                  3'h0, 3'h1: begin
                     // Deposit, bits outside the field cleared
                     valid    = 1'b1;
                     is_field = 1'b1;
                  end
                  3'h2, 3'h3: begin
                     // Merge, bits outside the field kept
                     valid    = 1'b1;
                     is_field = 1'b1;
                     fmrg     = 1'b1;
                  end
                  3'h4, 3'h5: begin
                     // Extract from the second source
                     valid    = 1'b1;
                     is_field = 1'b1;
                     is_ext   = 1'b1;
                  end
                  default: valid = 1'b0;
               endcase
            end
         end
         `LBU_OPC_MISC: begin
            if (ins[`LBU_MSUB4_HI:`LBU_MSUB4_LO] == `LBU_MISC_MARK) begin
               case (ins[`LBU_MSUB2_HI:`LBU_MSUB2_LO])
                  `LBU_MISC_BMERGE: begin
                     // Relies on the sequencer not running multiply/divide now
                     valid   = 1'b1;
                     oth_res = (src_a_r & ~mask_r) | (src_b_r & mask_r);
                  end
                  `LBU_MISC_EXCH: begin
                     // Pattern sits in the low five instruction bits
                     valid   = 1'b1;
                     oth_res = x0;
                  end
                  default: valid = 1'b0;
               endcase
            end
         end
         default: valid = 1'b0;
      endcase
   end

   // Field unit: shifting within 32 bits truncates the field at bit 31 for free
   always @* begin
      len_eff  = (fsz == 5'h00) ? `LBU_FULL_LEN : {1'b0, fsz};
      low_mask = ~(32'hFFFF_FFFF << len_eff);
      // Placed field mask is cut at bit 31 exactly like the data
      fld_mask = low_mask << fsh;
      dep_v    = (fsrc & low_mask) << fsh;
      if (fmrg)
         dep_v = (dest_r & ~fld_mask) | dep_v;
      // Vacated bits copy bit 31, so a field past the top comes out signed
      sh_v = $signed(fsrc) >>> fsh;
      fres = is_ext ? (sh_v & low_mask) : dep_v;
      res  = is_field ? fres : oth_res;
   end

   // Next register values; execution takes priority over a bus write
   always @* begin
      src_a_nxt = src_a_r;
      src_b_nxt = src_b_r;
      dest_nxt  = dest_r;
      sar_nxt   = sar_r;
      flr_nxt   = flr_r;
      mask_nxt  = mask_r;
      instr_nxt = instr_r;
      known_nxt = known_r;
      cond_nxt  = cond_out;
      if (wr_pend_r) begin
         case (wr_addr_r)
            `LBU_OFS_SRC_A:  src_a_nxt = hwdata;
            `LBU_OFS_SRC_B:  src_b_nxt = hwdata;
            `LBU_OFS_DEST:   dest_nxt  = hwdata;
            `LBU_OFS_STATUS: begin
               sar_nxt = hwdata[`LBU_SAR_HI:`LBU_SAR_LO];
               flr_nxt = hwdata[`LBU_FLR_HI:`LBU_FLR_LO];
            end
            `LBU_OFS_MASK:   mask_nxt  = hwdata;
            default:         instr_nxt = instr_r;
         endcase
      end
      // An issued instruction touches instruction register and recognised flag; a recognised one also destination and condition
      if (exec) begin
         instr_nxt = ins;
         known_nxt = valid;
         // Unknown instructions leave destination and condition alone
         if (valid) begin
            dest_nxt = res;
            if (btest)
               cond_nxt = (res[31:24] != 8'h00) && (res[23:16] != 8'h00) &&
                          (res[15:8] != 8'h00) && (res[7:0] != 8'h00);
            else
               cond_nxt = (res != 32'h0000_0000);
         end
      end
   end

   // Read mux uses next values so a read right after a write sees it
   always @* begin
      case (haddr[7:0])
         `LBU_OFS_SRC_A:  rd_mux = src_a_nxt;
         `LBU_OFS_SRC_B:  rd_mux = src_b_nxt;
         `LBU_OFS_DEST:   rd_mux = dest_nxt;
         `LBU_OFS_STATUS: rd_mux = {19'h0, flr_nxt, 3'h0, sar_nxt};
         `LBU_OFS_MASK:   rd_mux = mask_nxt;
         `LBU_OFS_INSTR:  rd_mux = {8'h00, instr_nxt};
         `LBU_OFS_COND:   rd_mux = {30'h0, known_nxt, cond_nxt};
         default:         rd_mux = 32'h0000_0000;
      endcase
      // Anything outside the low byte is unmapped and reads as zero
      if (haddr[31:8] != 24'h00_0000)
         rd_mux = 32'h0000_0000;
   end

   // Registers; zero wait states, so hreadyout is high both in and out of reset
   always @(posedge ref_clk) begin
      if (reset) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         src_a_r   <= `LBU_RST_WORD;
         src_b_r   <= `LBU_RST_WORD;
         dest_r    <= `LBU_RST_WORD;
         sar_r     <= `LBU_RST_FIVE;
         flr_r     <= `LBU_RST_FIVE;
         mask_r    <= `LBU_RST_WORD;
         instr_r   <= 24'h00_0000;
         known_r   <= 1'b0;
         cond_out  <= 1'b0;
         hrdata    <= `LBU_RST_WORD;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         // Writes outside the low byte never raise the pending flag, so they are dropped
         wr_pend_r <= addr_ok & hwrite & (haddr[31:8] == 24'h00_0000);
         wr_addr_r <= haddr[7:0];
         src_a_r   <= src_a_nxt;
         src_b_r   <= src_b_nxt;
         dest_r    <= dest_nxt;
         sar_r     <= sar_nxt;
         flr_r     <= flr_nxt;
         mask_r    <= mask_nxt;
         instr_r   <= instr_nxt;
         known_r   <= known_nxt;
         // Condition is valid right after the executing edge
         cond_out  <= cond_nxt;
         hrdata    <= rd_take ? rd_mux : 32'h0000_0000;
         // No wait states and no error responses, so these stay constant
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

endmodule

// ===== tb/lbu_top_sva.sv
// Checker for the unit's bus answers and condition output
`timescale 1ns/100ps
`include "lbu_defs.vh"

module lbu_top_sva (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        reset,
   // Bus seen at the unit
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Condition to the sequencer
   input wire logic        cond_out
);
   logic        dp_wr_r;   // Write data phase running
   logic        dp_rd_r;   // Read data phase running
   logic [31:0] dp_adr_r;  // Address of that data phase
   wire         ex_w  = dp_wr_r && dp_adr_r == {24'h0, `LBU_OFS_INSTR};  // Issue cycle
   wire  [2:0]  opc_w = hwdata[23:21];  // Opcode of the word being issued

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Follow each accepted address phase into its data phase
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dp_wr_r  <= 1'b0;
         dp_rd_r  <= 1'b0;
         dp_adr_r <= 32'h0;
      end else begin
         dp_wr_r  <= hsel && hready && htrans[1] && hwrite;
         dp_rd_r  <= hsel && hready && htrans[1] && !hwrite;
         dp_adr_r <= haddr;
      end
   end

   ready_high_a: assert property (hreadyout)
      else $error("slave inserted a wait state");
   resp_okay_a: assert property (!hresp)
      else $error("slave answered with an error response");
   idle_data_a: assert property (!dp_rd_r |-> hrdata == 32'h0)
      else $error("read data not zero outside a read data phase");
   cond_hold_a: assert property (!ex_w |=> $stable(cond_out))
      else $error("condition moved without an instruction");
   hwh_cond_a: assert property (ex_w && opc_w == `LBU_OPC_MHWH && hwdata[15:0] != 16'h0
      |=> cond_out)
      else $error("high halfword merge of nonzero constant gave false condition");
   ones_cond_a: assert property (ex_w && opc_w == `LBU_OPC_LOGIC && hwdata[10:6] == 5'h00
      |=> cond_out)
      else $error("all ones function gave false condition");
   zero_cond_a: assert property (ex_w && opc_w == `LBU_OPC_LOGIC && hwdata[10:6] == 5'h0F
      |=> !cond_out)
      else $error("all zeros function gave true condition");
   skip_cond_a: assert property (ex_w && opc_w == 3'h2 |=> $stable(cond_out))
      else $error("unknown opcode changed the condition");
   cond_read_a: assert property (dp_rd_r && dp_adr_r == {24'h0, `LBU_OFS_COND}
      |-> hrdata[0] == cond_out)
      else $error("condition register disagrees with condition output");
endmodule

bind lbu_top lbu_top_sva chk_u (
   .ref_clk   (ref_clk),
   .reset     (reset),
   .hsel      (hsel),
   .haddr     (haddr),
   .htrans    (htrans),
   .hwrite    (hwrite),
   .hwdata    (hwdata),
   .hready    (hready),
   .hrdata    (hrdata),
   .hreadyout (hreadyout),
   .hresp     (hresp),
   .cond_out  (cond_out)
);

// ===== tb/lbu_seq_model.sv
// Sequencer model: single word AHB-Lite master issuing instructions
`timescale 1ns/100ps

module lbu_seq_model (
   // Clock
   input  wire         ref_clk,
   // Master side of the bus
   output logic        hsel,
   output logic [31:0] haddr,
   output logic [1:0]  htrans,
   output logic        hwrite,
   output logic [2:0]  hsize,
   output logic [31:0] hwdata,
   input  wire         hready,
   input  wire  [31:0] hrdata,
   // Raised when the unit stops answering
   output logic        hang
);
   // Idle bus at time zero
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'hA5A5_A5A5;
      hang   = 1'b0;
   end

   // Bounded wait for hready, so a dead slave cannot stall the run
   task automatic wait_ready;
      int n;
      begin
         n = 0;
         @(posedge ref_clk);
         while (hready !== 1'b1 && n < 16) begin
            @(posedge ref_clk);
            n++;
         end
         if (n >= 16)
            hang <= 1'b1;
      end
   endtask

   // One word transfer; no multiply or divide runs here, so a bitwise merge is always legal
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      begin
         hsel   <= 1'b1;
         haddr  <= a;
         hwrite <= wr;
         htrans <= 2'h2;
         wait_ready();
         hsel   <= 1'b0;
         htrans <= 2'h0;
         haddr  <= ~a;
         hwdata <= wr ? d : ~hwdata;
         wait_ready();
         q = hrdata;
         // Released data lines never keep the last value
         hwdata <= ~hwdata;
      end
   endtask
endmodule

// ===== tb/lbu_top_bench.sv
// Self-checking bench for the logic and bit-field unit
`timescale 1ns/100ps

module lbu_top_bench;
   localparam logic [31:0] XM [0:4] = '{32'h5555_5555, 32'h3333_3333, 32'h0F0F_0F0F,
                                        32'h00FF_00FF, 32'h0000_FFFF};
   localparam logic [23:0] DIR [0:11] = '{24'hE007DF, 24'hE007DE, 24'hE007D8, 24'hE007A0,
      24'hC007C0, 24'hC04700, 24'h004720, 24'h004700, 24'hA00000, 24'hA003C0, 24'hA002A0,
      24'h600000};
   logic        ref_clk = 1'b0;  // Core clock
   logic        reset   = 1'b1;  // Synchronous reset
   wire         hsel, hwrite, hready, hresp, cond_out, hang;
   wire  [31:0] haddr, hwdata, hrdata;
   wire  [1:0]  htrans;
   wire  [2:0]  hsize;
   logic [31:0] sh [0:4];        // Shadow of source, dest, status and mask
   logic        cnd = 1'b0;      // Expected condition
   logic        rec = 1'b0;      // Expected recognised flag
   logic [31:0] q, ins;
   int          miscompares = 0;
   int          cmp_count   = 0;
   int          seed        = 49240;

   always #4 ref_clk = ~ref_clk;

   lbu_seq_model seq_u (.ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hang(hang));
   lbu_top dut_u (.ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .cond_out(cond_out));

   task automatic final_report;
      begin
         $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
         if (miscompares == 0 && cmp_count > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   // A dead bus counts as a mismatch and ends the run
   always @(posedge hang) begin
      miscompares++;
      final_report();
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      begin
         cmp_count++;
         if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
         end
      end
   endtask

   // Low l bits set; l of 32 gives a full word
   function automatic logic [31:0] msk(input int l);
      msk = 32'((64'h1 << l) - 64'h1);
   endfunction

   // Place field; size zero is full width, truncated at bit 31
   function automatic logic [31:0] dep(input logic [31:0] s, input int sf, input int ln,
                                       input logic m);
      int l;
      begin
         l = (ln == 0) ? 32 : ln;
         if (l + sf > 32)
            l = 32 - sf;
         dep = (s & msk(l)) << sf;
         if (m)
            dep = dep | (sh[2] & ~(msk(l) << sf));
      end
   endfunction

   // Arithmetic shift right, then keep low field
   function automatic logic [31:0] ext(input logic [31:0] s, input int sf, input int ln);
      logic signed [31:0] t;
      begin
         t = s;
         t = t >>> sf;
         ext = t & msk((ln == 0) ? 32 : ln);
      end
   endfunction

   // Reference behaviour of one issued instruction
   task automatic exec(input logic [23:0] i);
      logic [31:0] r;
      logic [4:0]  ln, sf;
      logic        bt;
      int          k;
      begin
         r   = 32'h0;
         bt  = 1'b0;
         rec = 1'b1;
         ln  = i[15:11];
         sf  = i[10:6];
         case (i[23:21])
            3'h0: r = dep(sh[1], sf, ln, i[5]);
            3'h6: r = ext(sh[1], sf, ln);
            3'h1: r = dep({{27{i[4]}}, i[4:0]}, sf, ln, 1'b1);
            3'h3: r = {i[15:0], sh[2][15:0]};
            3'h4: begin
               rec = (i[10:8] == 3'h7 && i[7:5] < 3'h6);
               sf  = sh[3][4:0];
               if (i[5])
                  ln = sh[3][12:8];
               r = i[7] ? ext(sh[1], sf, ln) : dep(sh[1], sf, ln, i[6]);
            end
            3'h5: begin
               rec = !i[10];
               bt  = i[5];
               for (k = 0; k < 32; k++)
                  r[k] = ~i[6 + {~sh[0][k], ~sh[1][k]}];
            end
            3'h7: begin
               rec = (i[10:7] == 4'hF && (i[6:5] == 2'h1 || i[6:5] == 2'h2));
               r   = (i[6:5] == 2'h1) ? (sh[0] & ~sh[4]) | (sh[1] & sh[4]) : sh[1];
               for (k = 4; k >= 0; k--)
                  if (i[6:5] == 2'h2 && i[k])
                     r = ((r & XM[k]) << (1 << k)) | ((r >> (1 << k)) & XM[k]);
            end
            default: rec = 1'b0;
         endcase
         if (rec) begin
            sh[2] = r;
            cnd = bt ? (|r[31:24] && |r[23:16] && |r[15:8] && |r[7:0]) : |r;
         end
      end
   endtask

   // Issue, then read back destination, condition and instruction
   task automatic run(input logic [23:0] i);
      begin
         seq_u.xfer(1'b1, 32'h14, {8'h0, i}, q);
         exec(i);
         seq_u.xfer(1'b0, 32'h08, 32'h0, q);
         chk("dest", sh[2], q);
         seq_u.xfer(1'b0, 32'h18, 32'h0, q);
         chk("cond reg", {30'h0, rec, cnd}, {30'h0, q[1:0]});
         chk("cond_out", {31'h0, cnd}, {31'h0, cond_out});
         seq_u.xfer(1'b0, 32'h14, 32'h0, q);
         chk("instr", {8'h0, i}, q);
      end
   endtask

   task automatic setreg(input int j, input logic [31:0] v);
      begin
         sh[j] = v;
         seq_u.xfer(1'b1, 32'(j * 4), v, q);
         seq_u.xfer(1'b0, 32'(j * 4), 32'h0, q);
         chk("register", v, q);
      end
   endtask

   // Main sequence: reset reads, directed cases, random traffic
   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      @(posedge ref_clk);
      for (int j = 0; j < 9; j++) begin
         seq_u.xfer(1'b0, (j == 8) ? 32'h100 : 32'(j * 4), 32'h0, q);
         chk("reset read", 32'h0, q);
      end
      seq_u.xfer(1'b1, 32'h1C, 32'h1234_5678, q);
      seq_u.xfer(1'b0, 32'h1C, 32'h0, q);
      chk("unmapped", 32'h0, q);
      setreg(0, 32'h0F0F_00FF);
      setreg(1, 32'h80FF_0001);
      setreg(2, 32'h1234_5678);
      setreg(3, 32'h0000_1B07);
      setreg(4, 32'hFFFF_0000);
      for (int j = 0; j < 12; j++)
         run(DIR[j]);
      for (int n = 0; n < 400; n++) begin
         ins = $random(seed);
         setreg(n % 5, (n % 5 == 3) ? ins & 32'h0000_1F1F : $random(seed));
         ins = $random(seed);
         if (ins[24] && ins[23:21] == 3'h4)
            ins[10:8] = 3'h7;
         if (ins[24] && ins[23:21] == 3'h5)
            ins[10] = 1'b0;
         if (ins[24] && ins[23:21] == 3'h7)
            ins[10:5] = ins[25] ? 6'h3D : 6'h3E;
         run(ins[23:0]);
      end
      final_report();
   end
endmodule
